// file: core/rbpc_top.sv
/*
 * reset merge, reset sequencing, brownout monitor and code read protection,
 * with an axi4-lite register slave and one level interrupt.
 * assumes one 40 mhz clock, all inputs synchronous except the reset pin,
 * comparator outputs per brownout level, and a flash controller handshake.
 */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`include "rbpc_defines.svh"
module rbpc_top #(
    parameter int EXT_MIN_CYC =
        (`RBPC_EXT_PULSE_NS + `RBPC_CLK_PERIOD_NS - 1) / `RBPC_CLK_PERIOD_NS,
    parameter int RELEASE_CYC = `RBPC_RELEASE_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset sources and supply monitor
    input wire logic reset_pin_n,
    input wire rbpc_pkg::rbpc_src_t src,
    // flash controller and boot
    input wire logic [31:0] crp_word,
    input wire logic flash_init_done,
    input wire logic boot_select_pin,
    output logic flash_init_req,
    output logic internal_rc_oscillator_on,
    // chip reset and processor start
    output logic chip_reset_n,
    output logic cpu_start,
    output logic [31:0] cpu_boot_addr,
    output logic boot_vector_map,
    // interrupts and policy
    output logic bod_irq_req,
    output logic core_bod_irq,
    output logic irq,
    output rbpc_pkg::rbpc_policy_t policy
);
    import rbpc_pkg::*;

    if (EXT_MIN_CYC < 1 || EXT_MIN_CYC > 255 || RELEASE_CYC < 1 || RELEASE_CYC > 255) begin : g_chk
        $error("rbpc_top: cycle counts must lie in 1..255");
    end

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_INIT,
        ST_RELEASE,
        ST_RUN
    } rbpc_state_t;

    function automatic rbpc_crp_lvl_t crp_decode(input logic [31:0] w);
        case (w)
            `RBPC_PAT_CRP1: crp_decode = RBPC_CRP_1;
            `RBPC_PAT_CRP2: crp_decode = RBPC_CRP_2;
            `RBPC_PAT_CRP3: crp_decode = RBPC_CRP_3;
            default: crp_decode = RBPC_CRP_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset pin: synchroniser and low-pulse qualifier

    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [7:0] low_cnt_reg;
    logic ext_req_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= reset_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // request is set once the pin has been low for the least pulse width and clears when the pin goes high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_reg <= 8'h00;
            ext_req_reg <= 1'b0;
        end else if (pin_sync_reg) begin
            low_cnt_reg <= 8'h00;
            ext_req_reg <= 1'b0;
        end else begin
            if (low_cnt_reg != 8'hff) begin
                low_cnt_reg <= low_cnt_reg + 8'h01;
            end
            if (low_cnt_reg >= 8'(EXT_MIN_CYC - 1)) begin
                ext_req_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and brownout compare

    logic [7:0] ctrl_reg;
    logic [`RBPC_EV_W-1:0] int_stat_reg;
    logic [`RBPC_EV_W-1:0] int_mask_reg;
    logic bod_prev_reg;
    logic bod_now;
    logic bod_rst;
    logic any_src;

    assign bod_now = src.bod_below[ctrl_reg[`RBPC_CTRL_IRQ_LVL]];
    assign bod_rst = src.bod_below[ctrl_reg[`RBPC_CTRL_RST_LVL]]
        & ctrl_reg[`RBPC_CTRL_RST_EN];
    assign any_src = ext_req_reg | src.wdt_req | src.por_req | bod_rst;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bod_irq_req <= 1'b0;
            core_bod_irq <= 1'b0;
            bod_prev_reg <= 1'b0;
        end else begin
            bod_irq_req <= bod_now;
            core_bod_irq <= bod_now & ctrl_reg[`RBPC_CTRL_IRQ_EN];
            bod_prev_reg <= bod_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer

    rbpc_state_t state_reg;
    logic [7:0] rel_cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_HOLD;
            rel_cnt_reg <= 8'h00;
            chip_reset_n <= 1'b0;
            cpu_start <= 1'b0;
            flash_init_req <= 1'b0;
            internal_rc_oscillator_on <= 1'b0;
        end else begin
            cpu_start <= 1'b0;
            flash_init_req <= 1'b0;
            case (state_reg)
                ST_HOLD: begin
                    chip_reset_n <= 1'b0;
                    if (src.supply_usable) begin
                        internal_rc_oscillator_on <= 1'b1;
                        flash_init_req <= 1'b1;
                        state_reg <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    // done seen while the request is still out is left from the last init
                    if (flash_init_done && !flash_init_req && !any_src) begin
                        rel_cnt_reg <= 8'h00;
                        state_reg <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (any_src) begin
                        state_reg <= ST_INIT;
                    end else if (rel_cnt_reg == 8'(RELEASE_CYC - 1)) begin
                        chip_reset_n <= 1'b1;
                        cpu_start <= 1'b1;
                        state_reg <= ST_RUN;
                    end else begin
                        rel_cnt_reg <= rel_cnt_reg + 8'h01;
                    end
                end
                ST_RUN: begin
                    if (any_src) begin
                        chip_reset_n <= 1'b0;
                        state_reg <= ST_HOLD;
                    end
                end
                default: begin
                    state_reg <= ST_HOLD;
                end
            endcase
        end
    end

    // boot address and vector map stay at reset values until the next reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_boot_addr <= `RBPC_BOOT_ADDR;
            boot_vector_map <= 1'b1;
        end else if (!chip_reset_n) begin
            cpu_boot_addr <= `RBPC_BOOT_ADDR;
            boot_vector_map <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // code read protection, latched when flash init finishes

    rbpc_crp_lvl_t crp_lvl_reg;
    logic no_isp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crp_lvl_reg <= RBPC_CRP_NONE;
            no_isp_reg <= 1'b0;
            policy <= '0;
        end else begin
            if (state_reg == ST_INIT && flash_init_done && !flash_init_req) begin
                crp_lvl_reg <= crp_decode(crp_word);
                no_isp_reg <= (crp_word == `RBPC_PAT_NOISP);
            end
            policy.flash_lock <= (crp_lvl_reg != RBPC_CRP_NONE);
            policy.debug_lock <= (crp_lvl_reg != RBPC_CRP_NONE);
            policy.isp_lock <= (crp_lvl_reg == RBPC_CRP_3);
            policy.iap_enable <= 1'b1;
            // boot pin sampled only while the part is leaving reset
            if (state_reg == ST_RELEASE) begin
                policy.isp_entry <= !boot_select_pin && !no_isp_reg
                    && (crp_lvl_reg != RBPC_CRP_3);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over a same-cycle clear

    logic [`RBPC_EV_W-1:0] ev_set;
    logic [`RBPC_EV_W-1:0] ev_clr;
    logic wr_fire;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    always_comb begin
        ev_set = '0;
        ev_set[`RBPC_EV_BOD] = bod_now & !bod_prev_reg;
        ev_set[`RBPC_EV_EXT] = ext_req_reg & (state_reg == ST_RUN);
        ev_set[`RBPC_EV_WDT] = src.wdt_req & (state_reg == ST_RUN);
        ev_set[`RBPC_EV_POR] = src.por_req & (state_reg == ST_RUN);
        ev_set[`RBPC_EV_BODRST] = bod_rst & (state_reg == ST_RUN);
    end

    assign ev_clr = (wr_fire && aw_addr_reg == `RBPC_OFF_INT_STAT && w_strb_reg[0])
        ? w_data_reg[`RBPC_EV_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_reg <= '0;
            irq <= 1'b0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~ev_clr) | ev_set;
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data taken in either order

    logic aw_got_reg;
    logic w_got_reg;

    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RBPC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RBPC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `RBPC_CTRL_RESET;
            int_mask_reg <= '0;
        end else if (wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == `RBPC_OFF_CTRL) begin
                ctrl_reg <= {2'b00, w_data_reg[5:0]};
            end
            if (aw_addr_reg == `RBPC_OFF_INT_MASK) begin
                int_mask_reg <= w_data_reg[`RBPC_EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read path; no register lies above the mask word

    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        case ({s_axi_araddr[3:2], 2'b00})
            `RBPC_OFF_CTRL: rd_word[7:0] = ctrl_reg;
            `RBPC_OFF_STATUS: rd_word[7:0] = {3'b000, pin_sync_reg,
                crp_lvl_reg, !chip_reset_n, bod_now};
            `RBPC_OFF_INT_STAT: rd_word[`RBPC_EV_W-1:0] = int_stat_reg;
            `RBPC_OFF_INT_MASK: rd_word[`RBPC_EV_W-1:0] = int_mask_reg;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RBPC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= `RBPC_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: core/rbpc_defines.svh
/*
 * constants of the reset and brownout control block: register offsets,
 * field positions, reset values, pattern codes and timing.
 * assumes inclusion by bare name from the package and the design module.
 */
`ifndef RBPC_DEFINES_SVH
`define RBPC_DEFINES_SVH

// register byte offsets
`define RBPC_OFF_CTRL 4'h0
`define RBPC_OFF_STATUS 4'h4
`define RBPC_OFF_INT_STAT 4'h8
`define RBPC_OFF_INT_MASK 4'hc

// control register fields
`define RBPC_CTRL_IRQ_LVL 1:0
`define RBPC_CTRL_RST_LVL 3:2
`define RBPC_CTRL_RST_EN 4
`define RBPC_CTRL_IRQ_EN 5
`define RBPC_CTRL_RESET 8'h00

// interrupt status bit positions
`define RBPC_EV_BOD 0
`define RBPC_EV_EXT 1
`define RBPC_EV_WDT 2
`define RBPC_EV_POR 3
`define RBPC_EV_BODRST 4
`define RBPC_EV_W 5

// flash patterns, arbitrary values
`define RBPC_PAT_CRP1 32'h1234_5678
`define RBPC_PAT_CRP2 32'h8765_4321
`define RBPC_PAT_CRP3 32'h4321_8765
`define RBPC_PAT_NOISP 32'h5678_1234

// processor start address after release
`define RBPC_BOOT_ADDR 32'h0000_0000

// timing
`define RBPC_CLK_PERIOD_NS 25
`define RBPC_EXT_PULSE_NS 50
`define RBPC_RELEASE_CYC 4

// bus responses
`define RBPC_RESP_OKAY 2'b00
`define RBPC_RESP_SLVERR 2'b10

`endif

// file: core/rbpc_pkg.sv
/*
 * types of the reset and brownout control block.
 * assumes rbpc_defines.svh is on the include path.
 */
package rbpc_pkg;
    `include "rbpc_defines.svh"

    typedef enum logic [1:0] {
        RBPC_CRP_NONE,
        RBPC_CRP_1,
        RBPC_CRP_2,
        RBPC_CRP_3
    } rbpc_crp_lvl_t;

    // reset and supply inputs from the outside
    typedef struct packed {
        logic wdt_req;
        logic por_req;
        logic supply_usable;
        logic [3:0] bod_below;
    } rbpc_src_t;

    // access policy towards flash, debug and programming
    typedef struct packed {
        logic flash_lock;
        logic debug_lock;
        logic isp_lock;
        logic iap_enable;
        logic isp_entry;
    } rbpc_policy_t;
endpackage

// file: bench/rbpc_top_properties.sv
/*
 * port checker for the reset and brownout control block.
 * assumes it is bound into rbpc_top, one clock, synchronous active-low aresetn.
 */
module rbpc_top_checker
    import rbpc_pkg::*;
#(
    parameter int EXT_MIN_CYC = 2,
    parameter int RELEASE_CYC = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sources and flash
    input wire rbpc_pkg::rbpc_src_t src,
    input wire logic flash_init_done,
    input wire logic flash_init_req,
    input wire logic internal_rc_oscillator_on,
    // chip reset, boot, interrupts, policy
    input wire logic chip_reset_n,
    input wire logic cpu_start,
    input wire logic [31:0] cpu_boot_addr,
    input wire logic boot_vector_map,
    input wire logic bod_irq_req,
    input wire logic core_bod_irq,
    input wire rbpc_pkg::rbpc_policy_t policy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    src_resets_a: assert property (chip_reset_n && (src.wdt_req || src.por_req) |=> !chip_reset_n)
        else $error("reset source did not pull chip reset");
    flash_start_a: assert property (flash_init_req |-> !chip_reset_n && internal_rc_oscillator_on)
        else $error("flash start outside reset or without oscillator");
    boot_addr_a: assert property (cpu_start |-> cpu_boot_addr == 32'h0 && boot_vector_map)
        else $error("processor start not at address zero");
    start_pulse_a: assert property ($rose(chip_reset_n) |-> cpu_start ##1 !cpu_start)
        else $error("start pulse not tied to reset release");
    release_gate_a: assert property ($rose(chip_reset_n) |->
        !$past(src.wdt_req) && !$past(src.por_req) && $past(flash_init_done))
        else $error("reset released with a source active");
    release_hold_a: assert property ($rose(chip_reset_n) |-> !$past(chip_reset_n, RELEASE_CYC))
        else $error("release phase too short");
    bod_high_a: assert property (&src.bod_below |=> bod_irq_req)
        else $error("brownout request missing");
    bod_low_a: assert property (!(|src.bod_below) |=> !bod_irq_req)
        else $error("brownout request without low supply");
    bod_gate_a: assert property (!(|src.bod_below) [*3] |-> !core_bod_irq)
        else $error("processor brownout interrupt without request");
    iap_on_a: assert property ($past(aresetn) |-> policy.iap_enable)
        else $error("application programming blocked");
    crp_order_a: assert property (policy.isp_lock |-> policy.flash_lock && policy.debug_lock)
        else $error("highest protection level without flash and debug lock");

    cover property (cpu_start);
    cover property (core_bod_irq);
    cover property (policy.isp_lock);
endmodule

bind rbpc_top rbpc_top_checker #(.EXT_MIN_CYC(EXT_MIN_CYC), .RELEASE_CYC(RELEASE_CYC)) u_chk (
    .aclk, .aresetn, .src, .flash_init_done, .flash_init_req, .internal_rc_oscillator_on,
    .chip_reset_n, .cpu_start, .cpu_boot_addr, .boot_vector_map, .bod_irq_req,
    .core_bod_irq, .policy);

// file: bench/rbpc_far_side.sv
/*
 * model of the reset circuitry, supply monitor and flash controller.
 * assumes the bench sets its control variables by non-blocking assignment.
 */
module rbpc_far_side
    import rbpc_pkg::*;
(
    // clock
    input wire logic aclk,
    // flash controller and pins
    input wire logic flash_init_req,
    output logic flash_init_done,
    output logic [31:0] crp_word,
    output logic reset_pin_n,
    output logic boot_select_pin,
    // reset sources and supply
    output rbpc_pkg::rbpc_src_t src
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] code_read_protection = 32'h0;
    logic wdt = 1'h0;
    logic por = 1'h0;
    logic sel = 1'h1;
    logic done = 1'h0;
    logic [3:0] brownout_detector = 4'h0;
    int dly = 2;
    int cnt = 3;

    initial reset_pin_n = 1'h1;
    assign src = {wdt, por, 1'h1, brownout_detector};
    assign boot_select_pin = sel;
    assign flash_init_done = done;
    // word is garbage until init completes
    assign crp_word = done ? code_read_protection : ~code_read_protection;

    always @(posedge aclk) begin
        if (flash_init_req) begin
            done <= 1'h0;
            cnt <= dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            done <= 1'h1;
        end
    end

    // n of at least two cycles keeps the pulse at 50 ns or more
    task automatic pulse(input int n);
        @(posedge aclk);
        reset_pin_n <= 1'h0;
        repeat (n) @(posedge aclk);
        reset_pin_n <= 1'h1;
    endtask
endmodule

// file: bench/reset_brownout_protect_ctrl_bench.sv
/*
 * self-checking bench of the reset and brownout control block.
 * assumes rbpc_pkg, rbpc_top, the far side model and the checker are compiled first.
 */
`include "rbpc_defines.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, s); end end

module reset_brownout_protect_ctrl_bench import rbpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, crp_word, cpu_boot_addr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reset_pin_n, flash_init_done, boot_select_pin, flash_init_req;
    logic internal_rc_oscillator_on, chip_reset_n, cpu_start, boot_vector_map;
    logic bod_irq_req, core_bod_irq, irq;
    rbpc_src_t src;
    rbpc_policy_t policy;
    int num_errors = 0;
    int check_count = 0;
    int flash_cnt = 0;
    logic [31:0] seed = 32'hd92c;
    logic [31:0] pat [5] = '{32'h0, `RBPC_PAT_CRP1, `RBPC_PAT_CRP2, `RBPC_PAT_CRP3,
        `RBPC_PAT_NOISP};

    rbpc_top DUT (.*);
    rbpc_far_side far (.aclk, .flash_init_req, .flash_init_done, .crp_word, .reset_pin_n,
        .boot_select_pin, .src);

    initial forever #12.5 aclk = ~aclk;
    always @(negedge aclk) if (flash_init_req) flash_cnt++;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic hang(input string what);
        num_errors++;
        $display("MISMATCH %s expected done seen timeout", what);
        end_sim();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 64);
        if (n >= 64) hang("write");
        s_axi_bready <= 1'h0;
        `CHK("bresp", `RBPC_RESP_OKAY, s_axi_bresp)
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 64);
        if (n >= 64) hang("read");
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        `CHK("rresp", `RBPC_RESP_OKAY, s_axi_rresp)
    endtask

    task automatic chk_rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(nm, e, v)
    endtask

    // chip reset may already be low on entry; waits for its rise
    task automatic boot();
        int n;
        logic low;
        low = 1'h0;
        for (n = 0; n < 400; n++) begin
            @(negedge aclk);
            if (!chip_reset_n) low = 1'h1;
            else if (low) break;
        end
        if (n >= 400) hang("boot");
        `CHK("cpu_start", 1'h1, cpu_start)
        `CHK("boot_addr", `RBPC_BOOT_ADDR, cpu_boot_addr)
        `CHK("vector_map", 1'h1, boot_vector_map)
        `CHK("flash_starts", 1, flash_cnt)
        `CHK("osc_on", 1'h1, internal_rc_oscillator_on)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        int i, b, n, lvl;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        boot();
        chk_rd("ctrl", `RBPC_OFF_CTRL, 32'h0);
        chk_rd("mask", `RBPC_OFF_INT_MASK, 32'h0);
        chk_rd("events", `RBPC_OFF_INT_STAT, 32'h0);
        wr(`RBPC_OFF_STATUS, 32'hff);
        chk_rd("status", `RBPC_OFF_STATUS, 32'h10);
        // pin, watchdog and power-on sources in turn, a different protection word latched each time
        for (i = 0; i < 5; i++) begin
            b = i % 3;
            lvl = (i < 4) ? i : 0;
            v = xs();
            far.code_read_protection <= pat[i];
            far.sel <= v[0];
            far.dly <= 1 + v[3:1];
            n = 2 + v[5:4];
            flash_cnt = 0;
            if (b == 0) begin
                far.pulse(n);
            end else begin
                if (b == 1) far.wdt <= 1'h1;
                else far.por <= 1'h1;
                repeat (n) @(posedge aclk);
                far.wdt <= 1'h0;
                far.por <= 1'h0;
            end
            boot();
            `CHK("policy", {lvl != 0, lvl != 0, lvl == 3, 1'h1, !v[0] && lvl != 3 && i != 4}, policy)
            chk_rd("level", `RBPC_OFF_STATUS, 32'h10 | (lvl << 2));
            chk_rd("events", `RBPC_OFF_INT_STAT, 32'h1 << (b + 1));
            wr(`RBPC_OFF_INT_STAT, 32'h1f);
            chk_rd("events", `RBPC_OFF_INT_STAT, 32'h0);
        end
        // each level selected in turn; the neighbouring level must not count
        for (i = 0; i < 4; i++) begin
            wr(`RBPC_OFF_CTRL, (i < 2 ? 32'h20 : 32'h0) | i);
            wr(`RBPC_OFF_INT_MASK, i & 1);
            far.brownout_detector <= 4'h1 << ((i + 1) % 4);
            chk_rd("bod_live", `RBPC_OFF_STATUS, 32'h10);
            `CHK("bod_req", 1'h0, bod_irq_req)
            far.brownout_detector <= 4'h1 << i;
            chk_rd("bod_live", `RBPC_OFF_STATUS, 32'h11);
            `CHK("bod_req", 1'h1, bod_irq_req)
            `CHK("bod_core", i < 2, core_bod_irq)
            repeat (3) @(posedge aclk);
            `CHK("irq", i[0], irq)
            chk_rd("events", `RBPC_OFF_INT_STAT, 32'h1);
            far.brownout_detector <= 4'h0;
            wr(`RBPC_OFF_INT_STAT, 32'h1);
            chk_rd("events", `RBPC_OFF_INT_STAT, 32'h0);
            `CHK("irq", 1'h0, irq)
            `CHK("no_bod_reset", 1'h1, chip_reset_n)
        end
        wr(`RBPC_OFF_CTRL, 32'h18);
        flash_cnt = 0;
        far.brownout_detector <= 4'hf;
        repeat (8) @(posedge aclk);
        `CHK("bod_reset", 1'h0, chip_reset_n)
        far.brownout_detector <= 4'h0;
        boot();
        rd(`RBPC_OFF_INT_STAT, v);
        `CHK("bod_event", 1'h1, v[4])
        end_sim();
    end
endmodule
